// [hdl/arc_top.sv]
// analog reference control register bank on the special-function register port
`timescale 1ns/1ps
`default_nettype none
`include "arc_cfg.svh"
module arc_top
    import arc_pkg::*;
#(
    parameter int OFFSET_W = 10
)
(
    // clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                reset_i,
    input  wire logic                clk_en_i,
    // register port
    input  wire logic [7:0]          sfr_addr_i,
    input  wire logic                sfr_wr_i,
    input  wire logic [7:0]          sfr_wdata_i,
    output logic [7:0]               sfr_rdata_o,
    // factory trim, static
    input  wire logic [OFFSET_W-1:0] factory_temp_offset_i,
    // converter phase
    input  wire logic                track_i,
    input  wire logic                convert_i,
    input  wire logic                temp_chan_i,
    // analog controls
    output logic [1:0]               vref_sel_o,
    output logic [1:0]               gnd_sel_o,
    output logic                     hs_ref_on_o,
    output logic                     prec_ref_on_o,
    output logic                     temp_on_o,
    output logic                     temp_out_oe_o
);
    // the byte split below only fits a ten-bit offset, so refuse others at elaboration
    if (OFFSET_W != 10)
    begin : g_bad_offset_w
        $error("arc_top: OFFSET_W must be 10");
    end

    logic [7:0] ref_ctrl;
    logic [7:0] next_ref_ctrl;
    logic [7:0] next_rdata;
    arc_ctrl_if ctrl ();

    // write path: only writable bits are kept
    always_comb
    begin
        next_ref_ctrl = ref_ctrl;
        if (sfr_wr_i && sfr_addr_i == `ARC_ADDR_REF_CTRL)
            next_ref_ctrl = sfr_wdata_i & `ARC_REF_CTRL_WMASK;
    end

    // control register, held while the clock enable is low
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            ref_ctrl <= `ARC_REF_CTRL_RESET;
        else if (clk_en_i)
            ref_ctrl <= next_ref_ctrl;
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        case (sfr_addr_i)
            `ARC_ADDR_REF_CTRL: next_rdata = ref_ctrl;
            `ARC_ADDR_FACTORY_TEMP_OFFSET_LO:  next_rdata = {factory_temp_offset_i[1:0], 6'h00};
            `ARC_ADDR_FACTORY_TEMP_OFFSET_HI:  next_rdata = factory_temp_offset_i[9:2];
            default:            next_rdata = 8'h00;
        endcase
    end

    // read data registered: valid the cycle after the address
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            sfr_rdata_o <= 8'h00;
        else if (clk_en_i)
            sfr_rdata_o <= next_rdata;
    end

    // fields out to the decoder
    assign ctrl.gnd_sel = ref_ctrl[`ARC_BIT_GND_SEL];
    assign ctrl.src_sel = arc_src_t'(ref_ctrl[`ARC_SRC_HI:`ARC_SRC_LO]);
    assign ctrl.temp_on = ref_ctrl[`ARC_BIT_TEMP_EN];
    assign ctrl.prec_on = ref_ctrl[`ARC_BIT_PREC_EN];

    arc_decode arc_decode_inst (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .clk_en_i      (clk_en_i),
        .ctrl          (ctrl),
        .track_i       (track_i),
        .convert_i     (convert_i),
        .temp_chan_i   (temp_chan_i),
        .vref_sel_o    (vref_sel_o),
        .gnd_sel_o     (gnd_sel_o),
        .hs_ref_on_o   (hs_ref_on_o),
        .prec_ref_on_o (prec_ref_on_o),
        .temp_on_o     (temp_on_o),
        .temp_out_oe_o (temp_out_oe_o)
    );
endmodule
`default_nettype wire

// [hdl/arc_cfg.svh]
// constants for the analog reference control register bank
`ifndef ARC_CFG_SVH
`define ARC_CFG_SVH
// Notes on behaviour
// - Reference source field bits 4:3 pick 00 external pin, 01 main supply, 10 digital supply, 11 high-speed reference.
// - Analog ground select bit 5 picks the ground pin when 0 and the analog ground pin when 1, in track and convert.
// - Temperature sensor enable bit 2 powers the sensor; while off its output is high impedance.
// - Precision reference enable bit 0 powers the precision reference and ties it to the external reference pin.
// - Bits 7:6 and 1 of the reference control register read zero and ignore writes.
// - With the high-speed reference selected it is enabled only while the converter needs it.
// - While the temperature sensor is the sampled input, sampling uses internal chip ground.
// - With the high-speed reference selected, conversion uses internal chip ground.
// - Offset low byte shows offset bits 1:0 in bits 7:6, other bits read zero, read-only.
// - Offset high byte shows offset bits 9:2, read-only.
`define ARC_ADDR_FACTORY_TEMP_OFFSET_LO   8'h85
`define ARC_ADDR_FACTORY_TEMP_OFFSET_HI   8'h86
`define ARC_ADDR_REF_CTRL  8'hD1
`define ARC_REF_CTRL_RESET 8'h18
`define ARC_REF_CTRL_WMASK 8'h3D
`define ARC_BIT_PREC_EN    0
`define ARC_BIT_TEMP_EN    2
`define ARC_SRC_LO         3
`define ARC_SRC_HI         4
`define ARC_BIT_GND_SEL    5
`endif

// [hdl/arc_pkg.sv]
// types for the analog reference control block
package arc_pkg;
    typedef enum logic [1:0] {
        ARC_SRC_EXT_PIN,
        ARC_SRC_MAIN_SUPPLY,
        ARC_SRC_DIG_SUPPLY,
        ARC_SRC_HS_REF
    } arc_src_t;
    typedef enum logic [1:0] {
        ARC_GND_PIN,
        ARC_GND_ANALOG_PIN,
        ARC_GND_INTERNAL
    } arc_gnd_t;
endpackage

// [hdl/arc_ctrl_if.sv]
// decoded control fields passed from the register file to the decoder
`timescale 1ns/1ps
`default_nettype none
interface arc_ctrl_if;
    import arc_pkg::*;
    logic     gnd_sel;
    arc_src_t src_sel;
    logic     temp_on;
    logic     prec_on;
    modport regs (output gnd_sel, src_sel, temp_on, prec_on);
    modport dec  (input gnd_sel, src_sel, temp_on, prec_on);
endinterface
`default_nettype wire

// [hdl/arc_decode.sv]
// turns control fields plus converter phase into analog switch controls
`timescale 1ns/1ps
`default_nettype none
`include "arc_cfg.svh"
module arc_decode
    import arc_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk_i,
    input  wire logic   reset_i,
    input  wire logic   clk_en_i,
    // fields and converter phase
    arc_ctrl_if.dec     ctrl,
    input  wire logic   track_i,
    input  wire logic   convert_i,
    input  wire logic   temp_chan_i,
    // analog controls
    output logic [1:0]  vref_sel_o,
    output logic [1:0]  gnd_sel_o,
    output logic        hs_ref_on_o,
    output logic        prec_ref_on_o,
    output logic        temp_on_o,
    output logic        temp_out_oe_o
);
    logic [1:0] next_vref_sel;
    logic [1:0] next_gnd_sel;
    logic       next_hs_on;
    arc_gnd_t   gnd_pick;

    // ground pick: internal overrides the select bit
    always_comb
    begin
        if (track_i && temp_chan_i)
            gnd_pick = ARC_GND_INTERNAL;
        else if (convert_i && ctrl.src_sel == ARC_SRC_HS_REF)
            gnd_pick = ARC_GND_INTERNAL;
        else if (ctrl.gnd_sel)
            gnd_pick = ARC_GND_ANALOG_PIN;
        else
            gnd_pick = ARC_GND_PIN;
        next_vref_sel = ctrl.src_sel;
        next_gnd_sel  = gnd_pick;
        // high-speed ref only runs while the converter is busy
        next_hs_on = (ctrl.src_sel == ARC_SRC_HS_REF) && (track_i || convert_i);
    end

    // registered so the analog switches never see decode glitches
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            vref_sel_o  <= 2'h3;
            gnd_sel_o   <= 2'h0;
            hs_ref_on_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            vref_sel_o  <= next_vref_sel;
            gnd_sel_o   <= next_gnd_sel;
            hs_ref_on_o <= next_hs_on;
        end
    end

    // enables follow the register bits directly
    assign prec_ref_on_o = ctrl.prec_on;
    assign temp_on_o     = ctrl.temp_on;
    assign temp_out_oe_o = ctrl.temp_on; // off means sensor output floats
endmodule
`default_nettype wire

// [tb/arc_props.sv]
// concurrent checks on the reference control bank ports
`timescale 1ns/1ps
`default_nettype none
module arc_props
(
    // clock, reset and register port
    input wire logic       sys_clk_i, reset_i, clk_en_i, sfr_wr_i,
    input wire logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o,
    // converter phase and analog controls
    input wire logic       track_i, convert_i, temp_chan_i,
    input wire logic [1:0] vref_sel_o, gnd_sel_o,
    input wire logic       hs_ref_on_o, prec_ref_on_o, temp_on_o, temp_out_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // an accepted write to the control register
    sequence s_ctl_wr; clk_en_i && sfr_wr_i && sfr_addr_i == 8'hD1; endsequence
    property p_prec; s_ctl_wr |=> prec_ref_on_o == $past(sfr_wdata_i[0]); endproperty
    a_prec: assert property (p_prec) else $error("precision enable wrong");
    property p_temp; s_ctl_wr |=> temp_on_o == $past(sfr_wdata_i[2]) && temp_out_oe_o == temp_on_o; endproperty
    a_temp: assert property (p_temp) else $error("sensor enable wrong");
    property p_rsv; clk_en_i && sfr_addr_i == 8'hD1 |=> sfr_rdata_o[7:6] == 2'h0 && !sfr_rdata_o[1]; endproperty
    a_rsv: assert property (p_rsv) else $error("unused control bits not zero");
    property p_factory_temp_offset; clk_en_i && sfr_addr_i == 8'h85 |=> sfr_rdata_o[5:0] == 6'h00; endproperty
    a_factory_temp_offset: assert property (p_factory_temp_offset) else $error("offset low byte spare bits not zero");
    property p_vref; s_ctl_wr ##1 clk_en_i |=> vref_sel_o == $past(sfr_wdata_i[4:3], 2); endproperty
    a_vref: assert property (p_vref) else $error("reference mux wrong");
    // second step has no override active, so the select bit alone decides
    property p_gnd; s_ctl_wr ##1 clk_en_i && !track_i && !convert_i |=> gnd_sel_o == {1'b0, $past(sfr_wdata_i[5], 2)};
    endproperty
    a_gnd: assert property (p_gnd) else $error("ground select wrong");
    property p_rdbk; s_ctl_wr ##1 clk_en_i && sfr_addr_i == 8'hD1 |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & 8'h3D);
    endproperty
    a_rdbk: assert property (p_rdbk) else $error("control readback wrong");
    property p_hs1; $past(clk_en_i) && hs_ref_on_o |-> vref_sel_o == 2'h3 && $past(track_i || convert_i); endproperty
    a_hs1: assert property (p_hs1) else $error("fast reference on when not needed");
    // no write one edge back, so the mux output still matches the field
    property p_hsconv; clk_en_i && $past(clk_en_i) && !$past(sfr_wr_i) && vref_sel_o == 2'h3 && convert_i
        |=> hs_ref_on_o && gnd_sel_o == 2'h2; endproperty
    a_hsconv: assert property (p_hsconv) else $error("conversion on fast reference wrong");
    property p_tsamp; clk_en_i && track_i && temp_chan_i |=> gnd_sel_o == 2'h2; endproperty
    a_tsamp: assert property (p_tsamp) else $error("sensor sampling ground wrong");
endmodule
bind arc_top arc_props arc_props_inst (.sys_clk_i, .reset_i, .clk_en_i, .sfr_wr_i, .sfr_addr_i, .sfr_wdata_i,
    .sfr_rdata_o, .track_i, .convert_i, .temp_chan_i, .vref_sel_o, .gnd_sel_o, .hs_ref_on_o, .prec_ref_on_o,
    .temp_on_o, .temp_out_oe_o);
`default_nettype wire

// [tb/test_analog_reference_control.sv]
// self-checking bench for the analog reference control bank
`timescale 1ns/1ps
`default_nettype none
module test_analog_reference_control;
    logic       sys_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, sfr_wr_i = 1'b0;
    logic       track_i = 1'b0, convert_i = 1'b0, temp_chan_i = 1'b0, hs_ref_on_o, prec_ref_on_o, temp_on_o;
    logic       temp_out_oe_o;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, d;
    logic [1:0] vref_sel_o, gnd_sel_o;
    logic [9:0] factory_temp_offset_i = 10'h2B5;
    int         fails = 0, cmp_count = 0;
    // rows: write data, track, convert, sensor channel, fast ref on, ground
    logic [13:0] tbl [6] = '{14'hF16, 14'hF25, 14'hF01, 14'hF2E, 14'h911, 14'h12A};
    always #25 sys_clk_i = ~sys_clk_i;
    arc_top #(.OFFSET_W(10)) arc_top_inst (.sys_clk_i, .reset_i, .clk_en_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
        .sfr_rdata_o, .factory_temp_offset_i, .track_i, .convert_i, .temp_chan_i, .vref_sel_o, .gnd_sel_o,
        .hs_ref_on_o, .prec_ref_on_o, .temp_on_o, .temp_out_oe_o);
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // inputs move only at the falling edge, away from sampling
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_addr_i = a;
        sfr_wdata_i = v;
        sfr_wr_i = 1'b1;
        cyc(1);
        sfr_wr_i = 1'b0;
    endtask
    // read data is registered, so it shows one edge after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_addr_i = a;
        cyc(1);
        chk("rdata", sfr_rdata_o, e);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // main sequence; spare control bits are written as ones only in the field-test loop
    initial
    begin
        cyc(5);
        reset_i = 1'b0;
        cyc(1);
        rd(8'hD1, 8'h18);
        chk("vref", 8'(vref_sel_o), 8'h03);
        for (int k = 0; k < 4; k++)
        begin
            d = {2'b11, k[0], k[1:0], k[1], 1'b1, !k[0]};
            wr(8'hD1, d);
            rd(8'hD1, d & 8'h3D);
            chk("vref", 8'(vref_sel_o), 8'(k));
            chk("gnd", 8'(gnd_sel_o), 8'(d[5]));
            chk("prec", 8'(prec_ref_on_o), 8'(d[0]));
            chk("temp", 8'({temp_out_oe_o, temp_on_o}), 8'({2{d[2]}}));
        end
        $display("field test done");
        rd(8'h85, 8'h40);
        rd(8'h86, 8'hAD);
        wr(8'h85, 8'hFF);
        rd(8'h85, 8'h40);
        rd(8'h3C, 8'h00);
        $display("offset test done");
        foreach (tbl[i])
        begin
            wr(8'hD1, tbl[i][13:6]);
            {track_i, convert_i, temp_chan_i} = tbl[i][5:3];
            cyc(1);
            chk("hs", 8'(hs_ref_on_o), 8'(tbl[i][2]));
            chk("gnd", 8'(gnd_sel_o), 8'(tbl[i][1:0]));
        end
        {track_i, convert_i, temp_chan_i} = 3'b000;
        $display("override test done");
        clk_en_i = 1'b0;
        wr(8'hD1, 8'h01);
        cyc(2);
        chk("frozen", 8'(prec_ref_on_o), 8'h00);
        clk_en_i = 1'b1;
        reset_i = 1'b1;
        cyc(1);
        reset_i = 1'b0;
        rd(8'hD1, 8'h18);
        // precision reference enabled once and then left alone to settle
        wr(8'hD1, 8'h01);
        rd(8'hD1, 8'h01);
        chk("prec", 8'(prec_ref_on_o), 8'h01);
        $display("freeze and reset test done");
        close_out();
    end
endmodule
`default_nettype wire
